//--- adcb_pkg.sv
package adcb_pkg;
   // Register offsets on the serial configuration port.
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_CUST_LO   = 8'h51;
   localparam logic [7:0] OFF_CUST_HI   = 8'h52;
   localparam logic [7:0] OFF_COM_OCEN  = 8'h53;
   localparam logic [7:0] OFF_COM_GNTC  = 8'h55;
   localparam logic [7:0] OFF_COM_PAT   = 8'h62;
   localparam logic [7:0] OFF_COM_PED   = 8'h63;
   localparam logic [7:0] OFF_CHB_OCEN  = 8'h66;
   localparam logic [7:0] OFF_CHB_GNTC  = 8'h68;
   localparam logic [7:0] OFF_CHB_TRIM  = 8'h6a;
   localparam logic [7:0] OFF_CHB_PAT   = 8'h75;
   localparam logic [7:0] OFF_CHB_PED   = 8'h76;
   // Field positions.
   localparam int CTRL_INDEP_BIT = 0;
   localparam int CTRL_SWRST_BIT = 1;
   localparam int OCEN_BIT       = 6;
   localparam int GAIN_LSB       = 4;
   localparam int TC_LSB         = 0;
   // Reset value of every stored register.
   localparam logic [7:0] REG_RST = 8'h00;
   // Serial frame: eight address bits then eight data bits.
   localparam int FRAME_BITS = 16;
   localparam int ADDR_BITS  = 8;
   // Loop time constant: code 0 is 2**18 cycles, code 11 is 2**29.
   localparam int          TC_BASE_SHIFT = 18;
   localparam logic [3:0]  TC_MAX_CODE   = 4'hb;
   // Ideal mid-codes and pattern words.
   localparam logic [19:0] MID_14     = 20'h02000;
   localparam logic [19:0] MID_12     = 20'h00800;
   localparam logic [13:0] TOGGLE_14  = 14'h1555;
   localparam int          FINE_SHIFT = 13;
   typedef enum logic [2:0] {
      ADCB_PAT_NORMAL = 3'h0,
      ADCB_PAT_ZEROS  = 3'h1,
      ADCB_PAT_ONES   = 3'h2,
      ADCB_PAT_TOGGLE = 3'h3,
      ADCB_PAT_RAMP   = 3'h4,
      ADCB_PAT_CUSTOM = 3'h5
   } adcb_pat_t;
endpackage

//--- adcb_spi.sv
`timescale 1ns/100ps
`default_nettype none
module adcb_spi (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       sclk_pin,
   input  wire logic       sdata_pin,
   input  wire logic       sen_n_pin,
   input  wire logic       hw_reset_pin,
   input  wire logic [7:0] rd_data,
   output logic            wr_stb,
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic [7:0]      rd_addr,
   output logic            hw_reset,
   output logic            sdout
);
   logic [3:0] m1_r;
   logic [3:0] m2_r;
   logic       sclk_d_r;
   logic [4:0] cnt_r;
   logic [15:0] sh_r;
   logic [7:0] out_r;
   logic       rise;

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers; only the second stage feeds logic.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         m1_r <= 4'h1;
         m2_r <= 4'h1;
      end else begin
         m1_r <= {hw_reset_pin, sdata_pin, sclk_pin, sen_n_pin};
         m2_r <= m1_r;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sclk_d_r <= 1'b0;
      else sclk_d_r <= m2_r[1];
   end

   assign rise     = m2_r[1] & ~sclk_d_r & ~m2_r[0];
   assign hw_reset = m2_r[3];
   assign rd_addr  = sh_r[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Frame shifter; a frame is restarted whenever enable goes high.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= 5'h00;
         sh_r   <= 16'h0000;
         out_r  <= 8'h00;
         wr_stb <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         wr_stb <= 1'b0;
         if (m2_r[0]) begin
            cnt_r <= 5'h00;
         end else if (rise) begin
            sh_r  <= {sh_r[14:0], m2_r[2]};
            cnt_r <= cnt_r + 5'h01;
            out_r <= {out_r[6:0], 1'b0};
            if (cnt_r == 5'(adcb_pkg::ADDR_BITS - 1)) begin
               out_r <= 8'h00;
            end
            if (cnt_r == 5'(adcb_pkg::FRAME_BITS - 1)) begin
               wr_stb  <= 1'b1;
               wr_addr <= sh_r[14:7];
               wr_data <= {sh_r[6:0], m2_r[2]};
            end
         end else if (cnt_r == 5'(adcb_pkg::ADDR_BITS) && sclk_d_r == 1'b1
                      && out_r == 8'h00 && sh_r[15:8] == 8'h00) begin
            out_r <= out_r;
         end
         // Readback word is loaded one cycle after the address is complete.
         if (!m2_r[0] && !rise && cnt_r == 5'(adcb_pkg::ADDR_BITS) && sclk_d_r) begin
            out_r <= rd_data;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sdout <= 1'b0;
      else sdout <= out_r[7];
   end
endmodule
`default_nettype wire

//--- adcb_trim_top.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Loop time constant code 0..11 gives 2**18 up to 2**29 clock cycles.
// - Channel B time constant, pattern, pedestal apply only in independent mode.
// - Fine trim is additive, 128 steps, gain factor 1 + trim/8192.
// - Total gain is coarse gain plus fine trim increment.
// - Pattern 000 passes data, 001 all zeros, 010 all ones.
// - Pattern 011 alternates 0101... and its complement each sample clock.
// - Pattern 100 on 14-bit ramps by one every clock, 0 to 16383.
// - Pattern 100 on 12-bit ramps by one every fourth clock, 0 to 4095.
// - Pattern 101 outputs the custom word from the two custom registers.
// - Enabled loop converges output to mid-code plus pedestal.
// - Pedestal is 6-bit two's complement, +31 to -32 LSB.
// - Custom word is 14 bits: low 8 and upper 6 from two registers.
module adcb_trim_top #(
   parameter int RES = 14
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   input  wire logic        SCLK,
   input  wire logic        SDATA,
   input  wire logic        SEN_N,
   input  wire logic        RESET,
   input  wire logic [13:0] CHB_ADC_DATA,
   output logic             SDOUT,
   output logic [13:0]      CHB_DOUT,
   output logic [3:0]       CHB_COARSE_GAIN
);
   localparam logic [13:0] DMASK = 14'((20'h1 << RES) - 20'h1);
   localparam logic [19:0] MID   = (RES == 14) ? adcb_pkg::MID_14 : adcb_pkg::MID_12;

   logic        wr_stb;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_data;
   logic [7:0]  rd_addr;
   logic [7:0]  rd_data;
   logic        hw_reset;
   logic        indep_r;
   logic [7:0]  cust_lo_r, cust_hi_r, com_ocen_r, com_gntc_r, com_pat_r, com_ped_r;
   logic [7:0]  chb_ocen_r, chb_gntc_r, fine_trim_code_r, chb_pat_r, chb_ped_r;
   logic        init;

   adcb_spi u_spi (
      .clk          (CORE_CLK),
      .rst_n        (RST_N),
      .sclk_pin     (SCLK),
      .sdata_pin    (SDATA),
      .sen_n_pin    (SEN_N),
      .hw_reset_pin (RESET),
      .rd_data      (rd_data),
      .wr_stb       (wr_stb),
      .wr_addr      (wr_addr),
      .wr_data      (wr_data),
      .rd_addr      (rd_addr),
      .hw_reset     (hw_reset),
      .sdout        (SDOUT)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register bank.
   // reset pin or software reset
   assign init = hw_reset
               | (wr_stb && wr_addr == adcb_pkg::OFF_CTRL && wr_data[adcb_pkg::CTRL_SWRST_BIT]);

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         indep_r <= 1'b0;
         {cust_lo_r, cust_hi_r, com_ocen_r, com_gntc_r} <= {4{adcb_pkg::REG_RST}};
         {com_pat_r, com_ped_r, chb_ocen_r, chb_gntc_r} <= {4{adcb_pkg::REG_RST}};
         {fine_trim_code_r, chb_pat_r, chb_ped_r}       <= {3{adcb_pkg::REG_RST}};
      end else if (init) begin
         indep_r <= 1'b0;
         {cust_lo_r, cust_hi_r, com_ocen_r, com_gntc_r} <= {4{adcb_pkg::REG_RST}};
         {com_pat_r, com_ped_r, chb_ocen_r, chb_gntc_r} <= {4{adcb_pkg::REG_RST}};
         {fine_trim_code_r, chb_pat_r, chb_ped_r}       <= {3{adcb_pkg::REG_RST}};
      end else if (wr_stb) begin
         case (wr_addr)
            adcb_pkg::OFF_CTRL:     indep_r          <= wr_data[adcb_pkg::CTRL_INDEP_BIT];
            adcb_pkg::OFF_CUST_LO:  cust_lo_r        <= wr_data;
            adcb_pkg::OFF_CUST_HI:  cust_hi_r        <= {2'h0, wr_data[5:0]};
            adcb_pkg::OFF_COM_OCEN: com_ocen_r       <= wr_data & 8'h40;
            adcb_pkg::OFF_COM_GNTC: com_gntc_r       <= wr_data;
            adcb_pkg::OFF_COM_PAT:  com_pat_r        <= wr_data & 8'h07;
            adcb_pkg::OFF_COM_PED:  com_ped_r        <= wr_data & 8'h3f;
            adcb_pkg::OFF_CHB_OCEN: chb_ocen_r       <= wr_data & 8'h40;
            adcb_pkg::OFF_CHB_GNTC: chb_gntc_r       <= wr_data;
            adcb_pkg::OFF_CHB_TRIM: fine_trim_code_r <= wr_data & 8'h7f;
            adcb_pkg::OFF_CHB_PAT:  chb_pat_r        <= wr_data & 8'h07;
            adcb_pkg::OFF_CHB_PED:  chb_ped_r        <= wr_data & 8'h3f;
            default: ;
         endcase
      end
   end

   always_comb begin
      case (rd_addr)
         adcb_pkg::OFF_CTRL:     rd_data = {7'h00, indep_r};
         adcb_pkg::OFF_CUST_LO:  rd_data = cust_lo_r;
         adcb_pkg::OFF_CUST_HI:  rd_data = cust_hi_r;
         adcb_pkg::OFF_COM_OCEN: rd_data = com_ocen_r;
         adcb_pkg::OFF_COM_GNTC: rd_data = com_gntc_r;
         adcb_pkg::OFF_COM_PAT:  rd_data = com_pat_r;
         adcb_pkg::OFF_COM_PED:  rd_data = com_ped_r;
         adcb_pkg::OFF_CHB_OCEN: rd_data = chb_ocen_r;
         adcb_pkg::OFF_CHB_GNTC: rd_data = chb_gntc_r;
         adcb_pkg::OFF_CHB_TRIM: rd_data = fine_trim_code_r;
         adcb_pkg::OFF_CHB_PAT:  rd_data = chb_pat_r;
         adcb_pkg::OFF_CHB_PED:  rd_data = chb_ped_r;
         default:                rd_data = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Effective channel B settings.
   logic       oc_en;
   logic [3:0] tc_code;
   logic [3:0] gain_code;
   logic [2:0] pat;
   logic [5:0] ped;

   assign oc_en     = indep_r ? chb_ocen_r[adcb_pkg::OCEN_BIT] : com_ocen_r[adcb_pkg::OCEN_BIT];
   assign tc_code   = indep_r ? chb_gntc_r[adcb_pkg::TC_LSB +: 4] : com_gntc_r[adcb_pkg::TC_LSB +: 4];
   assign gain_code = indep_r ? chb_gntc_r[adcb_pkg::GAIN_LSB +: 4]
                              : com_gntc_r[adcb_pkg::GAIN_LSB +: 4];
   assign pat       = indep_r ? chb_pat_r[2:0] : com_pat_r[2:0];
   assign ped       = indep_r ? chb_ped_r[5:0] : com_ped_r[5:0];

   // coarse gain goes to the analog stage; fine trim is added digitally.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) CHB_COARSE_GAIN <= 4'h0;
      else CHB_COARSE_GAIN <= gain_code;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gain trim and offset correction datapath.
   // Undefined codes above eleven are held at the slowest loop.
   function automatic logic signed [19:0] loop_corr(input logic signed [47:0] acc,
                                                    input logic [3:0] code);
      logic [3:0] c;
      logic signed [47:0] s;
      c = (code > adcb_pkg::TC_MAX_CODE) ? adcb_pkg::TC_MAX_CODE : code;
      s = acc >>> (adcb_pkg::TC_BASE_SHIFT + int'(c));
      return s[19:0];
   endfunction

   logic signed [47:0] acc_r;
   logic signed [19:0] s_c, g_c, c_c, target_c;
   logic signed [39:0] prod_c;
   logic [13:0]        norm_c;

   always_comb begin
      s_c    = $signed({6'h00, CHB_ADC_DATA & DMASK}) - $signed(MID);
      prod_c = s_c * $signed({13'h0000, fine_trim_code_r[6:0]});
      g_c    = s_c + prod_c[adcb_pkg::FINE_SHIFT +: 20];
      c_c    = g_c + (oc_en ? loop_corr(acc_r, tc_code) : 20'sh00000) + $signed(MID);
      if (c_c < 20'sh00000) norm_c = 14'h0000;
      else if (c_c > $signed({6'h00, DMASK})) norm_c = DMASK;
      else norm_c = c_c[13:0];
      // target is mid-code plus signed pedestal
      target_c = $signed(MID) + 20'(signed'(ped));
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) acc_r <= 48'sh0;
      else if (!oc_en) acc_r <= 48'sh0;
      else acc_r <= acc_r + 48'(target_c - $signed({6'h00, norm_c}));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test pattern generators; each restarts when its mode is entered.
   logic        tog_r;
   logic [1:0]  pre_r;
   logic [13:0] ramp_r;

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) tog_r <= 1'b0;
      else tog_r <= (pat == adcb_pkg::ADCB_PAT_TOGGLE) ? ~tog_r : 1'b0;
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pre_r  <= 2'h0;
         ramp_r <= 14'h0000;
      end else if (pat != adcb_pkg::ADCB_PAT_RAMP) begin
         pre_r  <= 2'h0;
         ramp_r <= 14'h0000;
      end else begin
         pre_r <= pre_r + 2'h1;
         // step every clock or every fourth
         if (RES == 14 || pre_r == 2'h3) ramp_r <= (ramp_r + 14'h0001) & DMASK;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) CHB_DOUT <= 14'h0000;
      else begin
         case (pat)
            adcb_pkg::ADCB_PAT_ZEROS:  CHB_DOUT <= 14'h0000;
            adcb_pkg::ADCB_PAT_ONES:   CHB_DOUT <= DMASK;
            adcb_pkg::ADCB_PAT_TOGGLE:
               CHB_DOUT <= (tog_r ? ~adcb_pkg::TOGGLE_14 : adcb_pkg::TOGGLE_14) & DMASK;
            adcb_pkg::ADCB_PAT_RAMP:   CHB_DOUT <= ramp_r;
            adcb_pkg::ADCB_PAT_CUSTOM: CHB_DOUT <= {cust_hi_r[5:0], cust_lo_r} & DMASK;
            default:                   CHB_DOUT <= norm_c;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- adcb_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module adcb_host_model (
   input  wire logic clk,
   input  wire logic sdout,
   output logic      sclk,
   output logic      sdata,
   output logic      sen_n
);
   initial begin
      sclk  = 1'b0;
      sdata = 1'b0;
      sen_n = 1'b1;
   end
   // Four clocks per half bit keeps each level past the pin synchroniser.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [15:0] f;
      f = {a, d};
      @(posedge clk);
      sen_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdata <= f[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (2) @(posedge clk);
      sen_n <= 1'b1;
      sdata <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   // Only fifteen rises are sent, so the frame is dropped and nothing is written.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      sen_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdata <= (i > 7) ? a[i - 8] : 1'b0;
         repeat (4) @(posedge clk);
         if (i < 8) d[i] = sdout;
         if (i > 0) sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (2) @(posedge clk);
      sen_n <= 1'b1;
      sdata <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

//--- adcb_trim_sva.sv
`timescale 1ns/100ps
`default_nettype none
module adcb_trim_chk #(
   parameter int RES = 14
) (
   input wire logic        CORE_CLK,
   input wire logic        RST_N,
   input wire logic        SCLK,
   input wire logic        SDATA,
   input wire logic        SEN_N,
   input wire logic        RESET,
   input wire logic [13:0] CHB_ADC_DATA,
   input wire logic        SDOUT,
   input wire logic [13:0] CHB_DOUT,
   input wire logic [3:0]  CHB_COARSE_GAIN
);
   // Shadow registers see a write earlier than the block, so q_r is zero first.
   logic [7:0]  rg_r [256];
   logic [14:0] sh_r;
   logic [4:0]  n_r;
   logic [3:0]  q_r;
   logic [1:0]  sc_r;
   logic [2:0]  pat;
   logic [13:0] msk;
   logic        full;
   logic        clr;
   logic        ocen;
   assign msk  = 14'h3fff >> (14 - RES);
   assign ocen = rg_r[0][0] ? rg_r[8'h66][6] : rg_r[8'h53][6];
   assign pat  = rg_r[0][0] ? rg_r[8'h75][2:0] : rg_r[8'h62][2:0];
   assign full = !SEN_N && sc_r == 2'h1 && n_r == 5'h0f;
   assign clr  = RESET || (full && sh_r[14:7] == 8'h00 && sh_r[0]);
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sc_r <= 2'h0;
         n_r  <= 5'h00;
         sh_r <= 15'h0000;
      end else begin
         sc_r <= {sc_r[0], SCLK};
         if (SEN_N)
            n_r <= 5'h00;
         else if (sc_r == 2'h1) begin
            sh_r <= {sh_r[13:0], SDATA};
            n_r  <= n_r + 5'h01;
         end
      end
   end
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N || clr) begin
         for (int i = 0; i < 256; i++)
            rg_r[i] <= 8'h00;
         q_r <= 4'h0;
      end else if (full) begin
         rg_r[sh_r[14:7]] <= {sh_r[6:0], SDATA};
         q_r <= 4'h0;
      end else if (q_r != 4'hf)
         q_r <= q_r + 4'h1;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   sequence quiet_in(logic [2:0] c);
      q_r == 4'hf && pat == c;
   endsequence
   zero_words_a: assert property (quiet_in(3'h1) |-> CHB_DOUT == 14'h0000)
      else $error("zero pattern word wrong");
   ones_words_a: assert property (quiet_in(3'h2) |-> CHB_DOUT == msk)
      else $error("ones pattern word wrong");
   toggle_flip_a: assert property (quiet_in(3'h3) ##1 q_r == 4'hf |->
      CHB_DOUT == (~$past(CHB_DOUT) & msk)) else $error("toggle word did not flip");
   ramp_step_a: assert property (quiet_in(3'h4) ##1 (q_r == 4'hf && RES == 14) |->
      CHB_DOUT == $past(CHB_DOUT) + 14'h0001) else $error("ramp did not step by one");
   custom_word_a: assert property (quiet_in(3'h5) |->
      CHB_DOUT == ({rg_r[8'h52][5:0], rg_r[8'h51]} & msk)) else $error("custom word wrong");
   pass_thru_a: assert property (q_r == 4'hf && (pat == 3'h0 || pat > 3'h5) && !ocen
      && rg_r[8'h6a] == 8'h00 |-> CHB_DOUT == ($past(CHB_ADC_DATA) & msk))
      else $error("data not passed");
   gain_select_a: assert property (q_r == 4'hf |-> CHB_COARSE_GAIN ==
      (rg_r[0][0] ? rg_r[8'h68][7:4] : rg_r[8'h55][7:4])) else $error("coarse gain source wrong");
   trim_gain_a: assert property (quiet_in(3'h0) and (RES == 14 && !ocen
      && rg_r[8'h6a][0] == 1'b0 && $past(CHB_ADC_DATA) == 14'h3000)
      |-> CHB_DOUT == 14'h3000 + 14'(rg_r[8'h6a][6:1]))
      else $error("fine trim step wrong");
   init_clear_a: assert property (RESET [*3] |-> ##[1:6] CHB_COARSE_GAIN == 4'h0)
      else $error("reset pin did not clear");
endmodule
bind adcb_trim_top adcb_trim_chk #(.RES(RES)) chk (
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .SCLK(SCLK), .SDATA(SDATA), .SEN_N(SEN_N),
   .RESET(RESET), .CHB_ADC_DATA(CHB_ADC_DATA), .SDOUT(SDOUT), .CHB_DOUT(CHB_DOUT),
   .CHB_COARSE_GAIN(CHB_COARSE_GAIN));
`default_nettype wire

//--- test_adc_chb_digital_trim_config.sv
`timescale 1ns/100ps
`default_nettype none
module test_adc_chb_digital_trim_config;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        rpin = 1'b0;
   logic [13:0] din = 14'h0000;
   logic        sclk, sdata, sen_n, sdout;
   logic [13:0] dout;
   logic [13:0] dout12;
   logic [3:0]  gain;
   int          mismatches = 0;
   int          comparisons = 0;
   always #25 clk = ~clk;
   adcb_trim_top #(.RES(14)) DUT (.CORE_CLK(clk), .RST_N(rst_n), .SCLK(sclk), .SDATA(sdata),
      .SEN_N(sen_n), .RESET(rpin), .CHB_ADC_DATA(din), .SDOUT(sdout), .CHB_DOUT(dout),
      .CHB_COARSE_GAIN(gain));
   // The 12-bit variant shares every input pin, so it sees the same register writes.
   adcb_trim_top #(.RES(12)) DUT12 (.CORE_CLK(clk), .RST_N(rst_n), .SCLK(sclk), .SDATA(sdata),
      .SEN_N(sen_n), .RESET(rpin), .CHB_ADC_DATA(din), .SDOUT(), .CHB_DOUT(dout12),
      .CHB_COARSE_GAIN());
   adcb_host_model host (.clk(clk), .sdout(sdout), .sclk(sclk), .sdata(sdata), .sen_n(sen_n));
   ////////////////////////////////////////
   task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic sample(input logic [13:0] v, output logic [13:0] o);
      @(posedge clk);
      din <= v;
      @(posedge clk);
      @(negedge clk);
      o = dout;
   endtask
   ////////////////////////////////////////
   task automatic t_pass();
      logic [13:0] o;
      logic [13:0] v [3] = '{14'h0000, 14'h3fff, 14'h1234};
      for (int i = 0; i < 3; i++) begin
         sample(v[i], o);
         check("pass", o, v[i]);
      end
   endtask
   task automatic t_common();
      logic [13:0] o;
      host.wr(8'h75, 8'h01);
      host.wr(8'h68, 8'h50);
      sample(14'h0abc, o);
      check("common pattern", o, 14'h0abc);
      check("common gain", {10'h000, gain}, 14'h0000);
      host.wr(8'h00, 8'h01);
      sample(14'h0abc, o);
      check("indep gain", {10'h000, gain}, 14'h0005);
      check("zeros", o, 14'h0000);
   endtask
   task automatic t_patterns();
      logic [13:0] a, b;
      logic [7:0]  r;
      host.wr(8'h51, 8'ha5);
      host.wr(8'h52, 8'hec);
      host.rd(8'h52, r);
      check("custom high readback", {6'h00, r}, 14'h002c);
      // Codes 6 and 7 are sent on purpose although a host should avoid them.
      for (int c = 2; c < 8; c++) begin
         host.wr(8'h75, 8'(c));
         repeat (20) @(negedge clk);
         a = dout;
         @(negedge clk);
         b = dout;
         case (c)
            2: check("ones", a, 14'h3fff);
            3: check("toggle", a, a[0] ? 14'h1555 : 14'h2aaa);
            4: check("ramp", b, a + 14'h0001);
            5: check("custom", a, 14'h2ca5);
            default: check("unused", a, 14'h0abc);
         endcase
         if (c == 3)
            check("toggle flip", b, ~a);
         if (c == 4) begin
            a = dout12;
            repeat (4) @(negedge clk);
            check("ramp12", dout12, a + 14'h0001);
         end
      end
   endtask
   task automatic t_loop();
      logic [13:0] o;
      host.wr(8'h6a, 8'h00);
      host.wr(8'h76, 8'h20);
      host.wr(8'h68, 8'h00);
      sample(14'h1fe0, o);
      host.wr(8'h66, 8'h40);
      repeat (5000) @(posedge clk);
      sample(14'h1fe0, o);
      check("pedestal hold", o, 14'h1fe0);
      sample(14'h1000, o);
      repeat (1000) @(posedge clk);
      sample(14'h1000, o);
      check("loop pull", {13'h0000, o >= 14'h100e && o <= 14'h1010}, 14'h0001);
   endtask
   task automatic t_trim();
      logic [13:0] o;
      host.wr(8'h75, 8'h00);
      host.wr(8'h6a, 8'h40);
      repeat (4) @(posedge clk);
      sample(14'h3000, o);
      check("trim", o, 14'h3020);
      sample(14'h2000, o);
      check("trim mid", o, 14'h2000);
      host.wr(8'h6a, 8'h7f);
      sample(14'h3fff, o);
      check("trim clamp", o, 14'h3fff);
   endtask
   task automatic t_reset();
      logic [13:0] o;
      host.wr(8'h00, 8'h02);
      check("soft reset gain", {10'h000, gain}, 14'h0000);
      host.wr(8'h00, 8'h01);
      host.wr(8'h75, 8'h02);
      host.wr(8'h68, 8'h30);
      // Reset pin pulse held long enough for the synchroniser.
      @(posedge clk);
      rpin <= 1'b1;
      repeat (4) @(posedge clk);
      rpin <= 1'b0;
      repeat (6) @(negedge clk);
      sample(14'h0123, o);
      check("pin reset data", o, 14'h0123);
      check("pin reset gain", {10'h000, gain}, 14'h0000);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_pass();
      t_common();
      t_patterns();
      t_trim();
      t_loop();
      t_reset();
      test_done();
   end
endmodule
`default_nettype wire
